// ===== bench/bog_burst_tb_top.sv
`timescale 1ns/10ps
module bog_burst_tb_top;
  logic        clk, srst, reg_we, reg_re, ext_req, key_req;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, rv;
  logic        ext_trig, manual_key, osc_half_pulse, osc_run_q, sync_n_q;
  logic        stop_lvl_en_q, sweep_trig_q;
  logic [14:0] stop_level_q;
  logic [21:0] phase_q;
  logic [1:0]  keying_pol_q, sweep_pol_q, seq_pol_q;
  int          mismatches, num_checks, cyc, run_cnt, idle_cnt, n, mark_len;
  // ****************************************
  // instances
  // ****************************************
  bog_burst uut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_q(reg_rdata_q), .ext_trig(ext_trig),
    .manual_key(manual_key), .osc_half_pulse(osc_half_pulse), .osc_run_q(osc_run_q),
    .sync_n_q(sync_n_q), .stop_lvl_en_q(stop_lvl_en_q), .stop_level_q(stop_level_q),
    .phase_q(phase_q), .sweep_trig_q(sweep_trig_q), .keying_pol_q(keying_pol_q),
    .sweep_pol_q(sweep_pol_q), .seq_pol_q(seq_pol_q));
  bog_src_model src (.clk(clk), .srst(srst), .ext_req(ext_req), .key_req(key_req),
    .ext_trig(ext_trig), .manual_key(manual_key), .osc_half_pulse(osc_half_pulse));
  // ****************************************
  // clock, watchdog, monitors
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // count half pulses seen while running and while stopped
  always @(posedge clk) begin
    cyc++;
    if (osc_half_pulse === 1'b1 && osc_run_q === 1'b1) run_cnt++;
    if (osc_half_pulse === 1'b1 && osc_run_q === 1'b0) idle_cnt++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  always @(negedge clk) begin
    if (!srst) chk("sync", 32'(!osc_run_q), 32'(sync_n_q));
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    rv = reg_rdata_q;
  endtask
  // negedges until run reaches v, bounded
  task automatic wait_run(logic v, int max);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (osc_run_q !== v && n < max);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    srst = 1'b1;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    ext_req = 1'b0;
    key_req = 1'b0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rd(bog_pkg::A_MARK);
    chk("mark reset", 32'h2, rv);
    rd(bog_pkg::A_SPACE);
    chk("space reset", 32'h2, rv);
    rd(8'h3C);
    chk("unmapped", 32'h0, rv);
    // every mode against every waveform kind
    for (int m = 0; m < 4; m++) begin
      for (int w = 0; w < 4; w++) begin
        wr(bog_pkg::A_CTRL, 32'(16 + w * 4 + m));
        rd(bog_pkg::A_STAT);
        chk("reject", 32'(w == 2 || (m < 2 && w == 1)), 32'(rv[1]));
      end
    end
    // manual trigger burst with a delay set, then a retrigger mid-burst
    wr(bog_pkg::A_MARK, 32'h3);
    wr(bog_pkg::A_DLYLO, 32'h64);
    wr(bog_pkg::A_CTRL, 32'h51);
    @(posedge clk);
    key_req <= 1'b1;
    wait_run(1'b1, 20);
    chk("manual latency", 32'h1, 32'(n <= 4));
    run_cnt = 0;
    @(posedge clk);
    key_req <= 1'b0;
    repeat (3) @(posedge clk);
    key_req <= 1'b1;
    wait_run(1'b0, 100);
    chk("mark count", 32'h3, 32'(run_cnt));
    wait_run(1'b1, 40);
    chk("no queued burst", 32'd40, 32'(n));
    @(posedge clk);
    key_req <= 1'b0;
    // manual trigger by register write, delay still skipped
    wr(bog_pkg::A_MAN, 32'h0);
    wait_run(1'b1, 10);
    chk("write trigger", 32'h1, 32'(n <= 3));
    wait_run(1'b0, 100);
    // external rise with no delay, then fall with 1 us delay
    for (int i = 0; i < 2; i++) begin
      wr(bog_pkg::A_DLYLO, 32'(i * 100));
      ext_req <= i[0];
      wr(bog_pkg::A_CTRL, i ? 32'h151 : 32'hD1);
      @(posedge clk);
      ext_req <= !i[0];
      wait_run(1'b1, 700);
      chk("ext latency", 32'h1, 32'(n >= 137 + 250 * i && n <= 145 + 250 * i));
      wait_run(1'b0, 100);
    end
    // gate: full unit, half unit, noise; delay still set
    for (int h = 0; h < 3; h++) begin
      wr(bog_pkg::A_CTRL, 32'hD2 | (h == 1 ? 32'h20 : 32'h0) | (h == 2 ? 32'h4 : 32'h0));
      // open the gate on a pulse so the half-cycle parity is known
      do @(posedge clk); while (osc_half_pulse !== 1'b1);
      ext_req <= 1'b1;
      wait_run(1'b1, 20);
      chk("gate start", 32'h1, 32'(n <= 4));
      repeat (20) @(posedge clk);
      // drop the gate right after a pulse so the next is far away
      do @(posedge clk); while (osc_half_pulse !== 1'b1);
      ext_req <= 1'b0;
      @(negedge clk);
      run_cnt = 0;
      wait_run(1'b0, 40);
      chk("gate stop pulses", 32'(2 - h), 32'(run_cnt));
    end
    // triggered gate toggled by the key
    wr(bog_pkg::A_CTRL, 32'h53);
    for (int t = 0; t < 2; t++) begin
      @(posedge clk);
      key_req <= 1'b1;
      wait_run(!t[0], 40);
      chk("toggle", 32'h1, 32'(n < 40));
      @(posedge clk);
      key_req <= 1'b0;
      repeat (30) @(negedge clk);
      chk("toggle hold", 32'(!t[0]), 32'(osc_run_q));
    end
    // auto burst with an external edge that must not matter
    wr(bog_pkg::A_SPACE, 32'h5);
    wr(bog_pkg::A_CTRL, 32'hD0);
    @(posedge clk);
    ext_req <= 1'b1;
    wait_run(1'b1, 100);
    wait_run(1'b0, 100);
    idle_cnt = 0;
    wait_run(1'b1, 100);
    chk("space count", 32'h5, 32'(idle_cnt));
    run_cnt = 0;
    wait_run(1'b0, 100);
    chk("auto mark", 32'h3, 32'(run_cnt));
    // phase and stop level fields
    wr(bog_pkg::A_PHASE, 32'h002488C0);
    wr(bog_pkg::A_STOPL, 32'h000058F0);
    wr(bog_pkg::A_CTRL, 32'h200);
    wr(bog_pkg::A_POL, 32'h24);
    @(negedge clk);
    chk("phase", 32'h2488C0, 32'(phase_q));
    chk("stop level", 32'h58F0, 32'(stop_level_q));
    chk("stop level on", 32'h1, 32'(stop_lvl_en_q));
    chk("polarities", 32'h6, 32'({keying_pol_q, sweep_pol_q, seq_pol_q}));
    // sweep generator at 1 us, burst generator at 2 us
    wr(bog_pkg::A_SPLO, 32'hA);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (sweep_trig_q !== 1'b1 && n < 600);
    end
    chk("sweep period", 32'h1, 32'(n >= 248 && n <= 252));
    wr(bog_pkg::A_PERLO, 32'h14);
    wr(bog_pkg::A_CTRL, 32'h11);
    wait_run(1'b1, 1000);
    wait_run(1'b0, 100);
    mark_len = n;
    wait_run(1'b1, 1000);
    chk("burst period", 32'h1, 32'(n + mark_len >= 496 && n + mark_len <= 504));
    give_verdict();
  end
endmodule

// ===== bench/bog_src_model.sv
`timescale 1ns/10ps
// ****************************************
// far side: trigger/gate source, panel key, oscillator phase
// ****************************************
module bog_src_model #(
  parameter int HP = 6  // cycles between half-cycle pulses
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ext_req,        // wanted trigger/gate level
  input  wire logic key_req,        // wanted key level
  output logic      ext_trig,
  output logic      manual_key,
  output logic      osc_half_pulse
);
  int cnt_q;  // stand-in for the running phase
  // lines move only just after an edge, like a real driver
  always_ff @(posedge clk) begin
    ext_trig <= ext_req;
    manual_key <= key_req;
    // phase keeps running while muted, so pulses never pause
    cnt_q <= (srst || cnt_q == HP - 1) ? 0 : cnt_q + 1;
    osc_half_pulse <= !srst && cnt_q == HP - 1;
  end
endmodule

// ===== core/bog_burst.sv
`timescale 1ns/10ps
// What this block does
// - auto: mark, then space, triggers ignored
// - trigger burst: mark count per trigger
// - gate: run whole or half cycles
// - noise gate: on/off directly with gate
// - triggered gate: trigger toggles running
// - reject noise/DC per mode
// - mark count in half cycles
// - space count in half cycles
// - gate stop unit full or half
// - start/stop phase shared with channel phase
// - programmable stop level or disabled
// - disabled level: freeze at stop phase
// - internal/external source, plus manual trigger
// - internal burst trigger period generator
// - trigger delay plus fixed latency
// - delay only trigger burst, not manual
// - sync output low while oscillating
// - external polarity rise/fall/off, independent uses
// - separate sweep and burst trigger generators
module bog_burst (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [31:0] reg_rdata_q,
  input  wire logic        ext_trig,       // external trigger/gate level
  input  wire logic        manual_key,     // panel key level
  input  wire logic        osc_half_pulse, // oscillator crossed stop phase or +180
  output logic             osc_run_q,      // oscillator output enabled
  output logic             sync_n_q,       // burst sync, low while running
  output logic             stop_lvl_en_q,  // hold stop level when stopped
  output logic      [14:0] stop_level_q,   // signed, 0.01 % of full scale
  output logic      [21:0] phase_q,        // signed, millidegrees
  output logic             sweep_trig_q,   // sweep internal trigger pulse
  output logic      [1:0]  keying_pol_q,
  output logic      [1:0]  sweep_pol_q,
  output logic      [1:0]  seq_pol_q
);
  // ****************************************
  // register file
  // ****************************************
  logic [9:0]              ctrl_q;      // control word
  logic [bog_pkg::CW-1:0]  mark_q;      // mark half-cycles
  logic [bog_pkg::CW-1:0]  space_q;     // space half-cycles
  logic [bog_pkg::TW-1:0]  per_q;       // burst period, 0.1 us units
  logic [bog_pkg::TW-1:0]  dly_q;       // delay, 0.01 us units
  logic [bog_pkg::TW-1:0]  sper_q;      // sweep period, 0.1 us units
  logic                    man_wr_q;    // manual trigger by write
  // decoded fields
  wire bog_pkg::bog_mode_type mode = bog_pkg::bog_mode_type'(ctrl_q[bog_pkg::F_MODE +: 2]);
  wire bog_pkg::bog_wave_type wave = bog_pkg::bog_wave_type'(ctrl_q[bog_pkg::F_WAVE +: 2]);
  wire       en_cfg   = ctrl_q[bog_pkg::F_EN];
  wire       half_sel = ctrl_q[bog_pkg::F_HALF];
  wire       ext_sel  = ctrl_q[bog_pkg::F_EXT];
  wire [1:0] epol     = ctrl_q[bog_pkg::F_EPOL +: 2];
  wire       is_burst = (mode == bog_pkg::M_AUTO) || (mode == bog_pkg::M_TRIG);
  wire       noise    = (wave == bog_pkg::W_NOISE);
  wire       cfg_bad  = (wave == bog_pkg::W_DC) || (is_burst && noise);
  wire       active   = en_cfg && !cfg_bad;
  // address decode
  wire       wr_ctrl  = reg_we && (reg_addr == bog_pkg::A_CTRL);
  wire       wr_man   = reg_we && (reg_addr == bog_pkg::A_MAN);
  // zero is taken as half a cycle
  wire [bog_pkg::CW-1:0] mark_n  = (mark_q == 21'h000000) ? 21'h000001 : mark_q;
  wire [bog_pkg::CW-1:0] space_n = (space_q == 21'h000000) ? 21'h000001 : space_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q        <= bog_pkg::CTRL_RST;
      mark_q        <= bog_pkg::HALF_RST;
      space_q       <= bog_pkg::HALF_RST;
      phase_q       <= 22'h000000;
      stop_level_q  <= 15'h0000;
      per_q         <= 34'h000000000;
      dly_q         <= 34'h000000000;
      sper_q        <= 34'h000000000;
      keying_pol_q  <= bog_pkg::POL_OFF;
      sweep_pol_q   <= bog_pkg::POL_OFF;
      seq_pol_q     <= bog_pkg::POL_OFF;
    end else if (reg_we) begin
      unique case (reg_addr)
        bog_pkg::A_CTRL:  ctrl_q       <= reg_wdata[9:0];
        bog_pkg::A_MARK:  mark_q       <= reg_wdata[bog_pkg::CW-1:0];
        bog_pkg::A_SPACE: space_q      <= reg_wdata[bog_pkg::CW-1:0];
        bog_pkg::A_PHASE: phase_q      <= reg_wdata[21:0];
        bog_pkg::A_STOPL: stop_level_q <= reg_wdata[14:0];
        bog_pkg::A_PERLO: per_q[31:0]  <= reg_wdata;
        bog_pkg::A_PERHI: per_q[33:32] <= reg_wdata[1:0];
        bog_pkg::A_DLYLO: dly_q[31:0]  <= reg_wdata;
        bog_pkg::A_DLYHI: dly_q[33:32] <= reg_wdata[1:0];
        bog_pkg::A_SPLO:  sper_q[31:0] <= reg_wdata;
        bog_pkg::A_SPHI:  sper_q[33:32] <= reg_wdata[1:0];
        bog_pkg::A_POL: begin
          keying_pol_q <= reg_wdata[1:0];
          sweep_pol_q  <= reg_wdata[3:2];
          seq_pol_q    <= reg_wdata[5:4];
        end
        default: ;  // unmapped writes dropped
      endcase
    end
  end

  // stop level enable mirrors the control bit
  assign stop_lvl_en_q = ctrl_q[bog_pkg::F_SLEN];
  // with it off the oscillator freezes at phase_q

  // ****************************************
  // trigger sources
  // ****************************************
  logic ext_d_q;   // previous external level
  logic key_d_q;   // previous key level
  logic tick100;   // 0.1 us tick
  logic tick10;    // 0.01 us tick
  logic int_pulse; // burst internal trigger
  logic sw_pulse;  // sweep internal trigger
  logic dly_done;
  wire ext_edge  = (epol == bog_pkg::POL_RISE) ? (ext_trig && !ext_d_q) :
                   (epol == bog_pkg::POL_FALL) ? (!ext_trig && ext_d_q) : 1'b0;
  wire ext_level = (epol == bog_pkg::POL_RISE) ? ext_trig :
                   (epol == bog_pkg::POL_FALL) ? !ext_trig : 1'b0;
  // manual trigger on top of selected source
  wire man_ev    = (manual_key && !key_d_q) || man_wr_q;
  wire src_ev    = ext_sel ? ext_edge : int_pulse;
  wire trig_ev   = src_ev || man_ev;

  always_ff @(posedge clk) begin
    if (srst) begin
      ext_d_q  <= 1'b0;
      key_d_q  <= 1'b0;
      man_wr_q <= 1'b0;
    end else begin
      ext_d_q  <= ext_trig;
      key_d_q  <= manual_key;
      man_wr_q <= wr_man;
    end
  end

  bog_tick #(.STEP(bog_pkg::CLK_NS), .UNIT(bog_pkg::PER_UNIT_NS)) u_tick100 (
    .clk  (clk),
    .srst (srst),
    .tick (tick100)
  );
  bog_tick #(.STEP(bog_pkg::CLK_NS), .UNIT(bog_pkg::DLY_UNIT_NS)) u_tick10 (
    .clk  (clk),
    .srst (srst),
    .tick (tick10)
  );
  // burst period generator, idle in auto mode
  bog_timer u_per (
    .clk   (clk),
    .srst  (srst),
    .clr   (!active || mode == bog_pkg::M_AUTO || ext_sel),
    .tick  (tick100),
    .limit (per_q),
    .done  (int_pulse)
  );
  // separate sweep generator with its own period
  bog_timer u_sweep (
    .clk   (clk),
    .srst  (srst),
    .clr   (sper_q == 34'h000000000),
    .tick  (tick100),
    .limit (sper_q),
    .done  (sw_pulse)
  );
  always_ff @(posedge clk) begin
    if (srst) sweep_trig_q <= 1'b0;
    else      sweep_trig_q <= sw_pulse;
  end

  // ****************************************
  // burst sequencer
  // ****************************************
  typedef enum logic [1:0] {
    S_STOP = 2'b00, S_DELAY = 2'b01, S_MARK = 2'b10, S_SPACE = 2'b11
  } bog_state_type;
  bog_state_type         st_q, st_d;
  logic [bog_pkg::CW-1:0] cnt_q, cnt_d;  // half-cycles left
  logic                  par_q, par_d;   // odd half-cycle done
  logic                  tg_q, tg_d;     // triggered-gate run flag
  logic                  ig_q;           // internal gate level
  logic [7:0]            lat_q;          // latency cycles left
  wire  last_half  = osc_half_pulse && (cnt_q == 21'h000001);
  wire  gate_on    = (mode == bog_pkg::M_TGATE) ? tg_q : (ext_sel ? ext_level : ig_q);
  // full cycle needs the odd half done
  wire  gate_stop  = noise ? 1'b1 : (osc_half_pulse && (half_sel || par_q));
  wire  lat_done   = (lat_q == 8'h00);
  wire  dly_fin    = lat_done && ((dly_q == 34'h000000000) || dly_done);

  // delay counts after the fixed latency
  bog_timer u_dly (
    .clk   (clk),
    .srst  (srst),
    .clr   (st_q != S_DELAY || !lat_done),
    .tick  (tick10),
    .limit (dly_q),
    .done  (dly_done)
  );

  // next state
  always_comb begin
    st_d  = st_q;
    cnt_d = osc_half_pulse ? cnt_q - 21'h000001 : cnt_q;
    par_d = osc_half_pulse ? !par_q : par_q;
    tg_d  = tg_q;
    if (mode == bog_pkg::M_TGATE && trig_ev) tg_d = !tg_q;
    if (mode != bog_pkg::M_TGATE || !active) tg_d = 1'b0;
    if (!active || wr_ctrl) begin
      st_d = S_STOP;  // off, rejected, or control rewritten: no stale count survives
    end else begin
      unique case (mode)
        bog_pkg::M_AUTO: begin
          if (st_q == S_STOP || st_q == S_DELAY) begin
            st_d  = S_MARK;
            cnt_d = mark_n;
          end else if (last_half) begin
            st_d  = (st_q == S_MARK) ? S_SPACE : S_MARK;
            cnt_d = (st_q == S_MARK) ? space_n : mark_n;
          end
        end
        bog_pkg::M_TRIG: begin
          if (st_q == S_STOP && trig_ev) begin
            st_d  = man_ev ? S_MARK : S_DELAY;
            cnt_d = mark_n;
          end else if (st_q == S_DELAY) begin
            cnt_d = mark_n;
            if (dly_fin) st_d = S_MARK;
          end else if (st_q != S_STOP && last_half) begin
            st_d = S_STOP;
          end
        end
        default: begin
          if (st_q != S_MARK) begin
            st_d  = gate_on ? S_MARK : S_STOP;
            par_d = 1'b0;
          // noise stops on the gate itself
          end else if (!gate_on && gate_stop) begin
            st_d = S_STOP;
          end
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q  <= S_STOP;
      cnt_q <= 21'h000000;
      par_q <= 1'b0;
      tg_q  <= 1'b0;
      ig_q  <= 1'b0;
      lat_q <= 8'h00;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      par_q <= par_d;
      tg_q  <= tg_d;
      // internal source in gate mode gives a square gate
      ig_q  <= int_pulse ? !ig_q : ig_q;
      // reload latency when a delay begins
      if (st_q != S_DELAY)  lat_q <= 8'(bog_pkg::LAT_CYC - 1);
      else if (!lat_done)   lat_q <= lat_q - 8'h01;
    end
  end

  // sync is the inverse of running
  always_ff @(posedge clk) begin
    if (srst) begin
      osc_run_q <= 1'b0;
      sync_n_q  <= 1'b1;
    end else begin
      osc_run_q <= (st_d == S_MARK);
      sync_n_q  <= (st_d != S_MARK);
    end
  end

  // ****************************************
  // read port
  // ****************************************
  wire [31:0] stat_w = {28'h0000000, !sync_n_q, st_q == S_DELAY, cfg_bad, osc_run_q};
  wire [31:0] rd_w =
    (reg_addr == bog_pkg::A_CTRL)  ? {22'h000000, ctrl_q} :
    (reg_addr == bog_pkg::A_MARK)  ? {11'h000, mark_q} :
    (reg_addr == bog_pkg::A_SPACE) ? {11'h000, space_q} :
    (reg_addr == bog_pkg::A_PHASE) ? {10'h000, phase_q} :
    (reg_addr == bog_pkg::A_STOPL) ? {17'h00000, stop_level_q} :
    (reg_addr == bog_pkg::A_PERLO) ? per_q[31:0] :
    (reg_addr == bog_pkg::A_PERHI) ? {30'h00000000, per_q[33:32]} :
    (reg_addr == bog_pkg::A_DLYLO) ? dly_q[31:0] :
    (reg_addr == bog_pkg::A_DLYHI) ? {30'h00000000, dly_q[33:32]} :
    (reg_addr == bog_pkg::A_SPLO)  ? sper_q[31:0] :
    (reg_addr == bog_pkg::A_SPHI)  ? {30'h00000000, sper_q[33:32]} :
    (reg_addr == bog_pkg::A_POL)   ? {26'h0000000, seq_pol_q, sweep_pol_q, keying_pol_q} :
    (reg_addr == bog_pkg::A_STAT)  ? stat_w : 32'h00000000;
  // data only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) reg_rdata_q <= 32'h00000000;
    else      reg_rdata_q <= reg_re ? rd_w : 32'h00000000;
  end

  // ****************************************
  // checks
  // ****************************************
  property p_sync;
    @(posedge clk) disable iff (srst) sync_n_q == !osc_run_q;
  endproperty
  a_sync: assert property (p_sync) else $error("sync not inverse of run");
  property p_auto;
    @(posedge clk) disable iff (srst)
      (mode == bog_pkg::M_AUTO && active && !wr_ctrl && st_q == S_STOP) |=> osc_run_q;
  endproperty
  a_auto: assert property (p_auto) else $error("auto burst did not start");
  property p_rej;
    @(posedge clk) disable iff (srst) cfg_bad |=> !osc_run_q;
  endproperty
  a_rej: assert property (p_rej) else $error("rejected waveform ran");
  property p_ign;
    @(posedge clk) disable iff (srst)
      (mode == bog_pkg::M_TRIG && active && !wr_ctrl && st_q == S_MARK && trig_ev
       && !last_half) |=> st_q == S_MARK;
  endproperty
  a_ign: assert property (p_ign) else $error("trigger restarted burst");
  property p_man;
    @(posedge clk) disable iff (srst)
      (mode == bog_pkg::M_TRIG && active && !wr_ctrl && st_q == S_STOP && man_ev)
      |=> st_q == S_MARK;
  endproperty
  a_man: assert property (p_man) else $error("manual trigger delayed");
  property p_lat;
    @(posedge clk) disable iff (srst)
      (st_q == S_STOP && st_d == S_DELAY && !man_ev) |=> (st_q == S_DELAY)[*8];
  endproperty
  a_lat: assert property (p_lat) else $error("latency cut short");
  property p_noise;
    @(posedge clk) disable iff (srst)
      (mode == bog_pkg::M_GATE && active && noise && !wr_ctrl && st_q == S_MARK
       && !gate_on) |=> !osc_run_q;
  endproperty
  a_noise: assert property (p_noise) else $error("noise gate kept running");
  property p_tgl;
    @(posedge clk) disable iff (srst)
      (mode == bog_pkg::M_TGATE && active && !wr_ctrl && trig_ev) |=> tg_q != $past(tg_q);
  endproperty
  a_tgl: assert property (p_tgl) else $error("trigger did not toggle gate");
  property p_end;
    @(posedge clk) disable iff (srst)
      (mode == bog_pkg::M_TRIG && active && !wr_ctrl && st_q == S_MARK && last_half)
      |=> !osc_run_q;
  endproperty
  a_end: assert property (p_end) else $error("burst overran mark count");
endmodule

// ===== core/bog_pkg.sv
package bog_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_NS   = 4;      // 250 MHz period
  localparam int LAT_NS   = 550;    // inherent trigger latency
  localparam int LAT_CYC  = (LAT_NS + CLK_NS - 1) / CLK_NS;  // rounded up
  localparam int PER_UNIT_NS = 100; // internal trigger period step
  localparam int DLY_UNIT_NS = 10;  // trigger delay step
  localparam int TW       = 34;     // width of period and delay counts
  localparam int CW       = 21;     // half-cycle count width
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_MARK  = 8'h04;
  localparam logic [7:0] A_SPACE = 8'h08;
  localparam logic [7:0] A_PHASE = 8'h0C;
  localparam logic [7:0] A_STOPL = 8'h10;
  localparam logic [7:0] A_PERLO = 8'h14;
  localparam logic [7:0] A_PERHI = 8'h18;
  localparam logic [7:0] A_DLYLO = 8'h1C;
  localparam logic [7:0] A_DLYHI = 8'h20;
  localparam logic [7:0] A_STAT  = 8'h24;
  localparam logic [7:0] A_MAN   = 8'h28;
  localparam logic [7:0] A_SPLO  = 8'h2C;
  localparam logic [7:0] A_SPHI  = 8'h30;
  localparam logic [7:0] A_POL   = 8'h34;
  // ****************************************
  // control field positions
  // ****************************************
  localparam int F_MODE = 0;   // 2 bits
  localparam int F_WAVE = 2;   // 2 bits
  localparam int F_EN   = 4;
  localparam int F_HALF = 5;
  localparam int F_EXT  = 6;
  localparam int F_EPOL = 7;   // 2 bits
  localparam int F_SLEN = 9;
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [CW-1:0] HALF_RST = 21'h000002;  // one full cycle
  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [1:0] {
    M_AUTO = 2'b00, M_TRIG = 2'b01, M_GATE = 2'b10, M_TGATE = 2'b11
  } bog_mode_type;
  typedef enum logic [1:0] {
    W_STD = 2'b00, W_NOISE = 2'b01, W_DC = 2'b10, W_ARB = 2'b11
  } bog_wave_type;
  localparam logic [1:0] POL_OFF  = 2'h0;
  localparam logic [1:0] POL_RISE = 2'h1;
  localparam logic [1:0] POL_FALL = 2'h2;
endpackage

// ===== core/bog_tick.sv
`timescale 1ns/10ps
// fractional divider: one-cycle pulse every UNIT ns on average
module bog_tick #(
  parameter int STEP = 4,
  parameter int UNIT = 10
) (
  input  wire logic clk,
  input  wire logic srst,
  output logic      tick
);
  logic [15:0] acc_q;      // phase remainder in ns
  wire  [15:0] acc_n = acc_q + 16'(STEP);
  wire         wrap  = (acc_n >= 16'(UNIT));
  // exact on average, jitter of up to one clock, none when UNIT is a multiple of STEP
  always_ff @(posedge clk) begin
    if (srst) begin
      acc_q <= 16'h0000;
      tick  <= 1'b0;
    end else begin
      acc_q <= wrap ? acc_n - 16'(UNIT) : acc_n;
      tick  <= wrap;
    end
  end
endmodule

// ===== core/bog_timer.sv
`timescale 1ns/10ps
// counts ticks up to limit, pulses done and restarts
module bog_timer (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  clr,    // hold at zero
  input  wire logic                  tick,
  input  wire logic [bog_pkg::TW-1:0] limit,
  output logic                       done
);
  logic [bog_pkg::TW-1:0] cnt_q;
  wire  [bog_pkg::TW-1:0] cnt_n = cnt_q + 34'h000000001;
  wire                    hit   = tick && (cnt_n >= limit);
  // a limit of zero behaves like one tick
  always_ff @(posedge clk) begin
    if (srst || clr) begin
      cnt_q <= 34'h000000000;
      done  <= 1'b0;
    end else begin
      cnt_q <= hit ? 34'h000000000 : (tick ? cnt_n : cnt_q);
      done  <= hit;
    end
  end
endmodule
